/* inc/ovp_defs.svh */
// register map, reset values and timing counts of the overvoltage stages
// assumes a 50 MHz system clock and a millisecond time base for all delays
`ifndef OVP_DEFS_SVH
`define OVP_DEFS_SVH

`define OVP_ADDR_CTRL       12'h000
`define OVP_ADDR_FORCE      12'h004
`define OVP_ADDR_HYST       12'h008
`define OVP_ADDR_HOLD       12'h00C
`define OVP_ADDR_UNOM       12'h010
`define OVP_ADDR_STATUS     12'h014
`define OVP_ADDR_CNT_CLR    12'h018
`define OVP_ADDR_LOG_SEL    12'h01C
`define OVP_ADDR_LOG_DATE   12'h020
`define OVP_ADDR_LOG_TIME   12'h024
`define OVP_ADDR_LOG_INFO   12'h028
`define OVP_ADDR_COUNT_BASE 12'h030
`define OVP_ADDR_PRIM_BASE  12'h040
`define OVP_ADDR_SET_BASE   12'h080
`define OVP_ADDR_SET_END    12'h0B0

`define OVP_CTRL_RESET      32'h0000_0000
`define OVP_SET_RESET       32'h0064_044C
`define OVP_HYST_RESET      10'h01E
`define OVP_HOLD_RESET      16'h0032
`define OVP_UNOM_RESET      20'h02710
`define OVP_PERMILLE        10'h3E8
`define OVP_PCT_FULL        8'h64

`define OVP_CLK_HZ          50000000
`define OVP_TICK_MS         1
`define OVP_TICK_CYCLES     (`OVP_CLK_HZ / 1000 * `OVP_TICK_MS)
`define OVP_FORCE_TIMEOUT_S 300
`define OVP_FORCE_TICKS     (`OVP_FORCE_TIMEOUT_S * 1000 / `OVP_TICK_MS)

`endif

/* inc/ovp_pkg.sv */
// types shared by the overvoltage stages and their bench
// assumes nothing beyond a SystemVerilog compiler
package ovp_pkg;

    typedef enum logic [1:0] {
        OVP_IDLE    = 2'b00,
        OVP_BLOCKED = 2'b01,
        OVP_START   = 2'b10,
        OVP_TRIP    = 2'b11
    } ovp_status_type;

    typedef enum logic [2:0] {
        OVP_SRC_NONE      = 3'b000,
        OVP_SRC_DIGITAL   = 3'b001,
        OVP_SRC_VIRTUAL   = 3'b010,
        OVP_SRC_INDICATOR = 3'b011,
        OVP_SRC_SOFT_OUT  = 3'b100,
        OVP_SRC_FKEY      = 3'b101
    } ovp_src_type;

    // fundamental magnitudes, 0.1 % of nominal per lsb
    typedef struct packed {
        logic [15:0] line_voltage_a_b;
        logic [15:0] line_voltage_b_c;
        logic [15:0] line_voltage_c_a;
    } ovp_volt_type;

    typedef struct packed {
        logic [2:0] start;
        logic [2:0] trip;
    } ovp_flags_type;

    typedef struct packed {
        logic [31:0] date;
        logic [31:0] tod_ms;
    } ovp_stamp_type;

    typedef struct packed {
        logic [21:0] rsv;
        logic [2:0]  sel_line;
        ovp_src_type group_select_source;
        logic [1:0]  alt_group;
        logic [1:0]  manual_group;
    } ovp_ctrl_type;

    typedef struct packed {
        logic [24:0] rsv;
        logic [2:0]  trip;
        logic [2:0]  start;
        logic        flag;
    } ovp_force_type;

    typedef struct packed {
        logic [3:0]  rsv;
        logic [1:0]  stage;
        logic [1:0]  active_group_index;
        logic [7:0]  elapsed_delay_percent;
        logic [15:0] fault_peak_voltage;
    } ovp_info_type;

    typedef struct packed {
        ovp_stamp_type stamp;
        ovp_info_type  info;
    } ovp_log_type;

endpackage

/* hw/ovp_stages.sv */
// three definite-time overvoltage stages with fault log, behind an AHB-Lite slave
// assumes fundamental magnitudes, timestamp and group inputs synchronous to hclk
//
// What this block does
// [RULE_01] compare the largest line-to-line voltage against each stage
// [RULE_02] inputs are fundamental magnitudes in any measuring mode
// [RULE_03] a stage picks up and starts when the maximum exceeds its pick-up
// [RULE_04] trip when pick-up outlasts the operate time
// [RULE_05] three stages, each with own pick-up and operate delay
// [RULE_06] first stage keeps its operate timer until the release delay elapses
// [RULE_07] a returning fault resumes the first stage timer
// [RULE_08] release below pick-up minus a settable dead band, 3 percent by default
// [RULE_09] four setting groups per stage, picked manually or by an input
// [RULE_10] group select source: none, digital, virtual, indicator, soft output, key
// [RULE_11] each stage reports idle, blocked, start or trip
// [RULE_12] clearable cumulative start counter per stage
// [RULE_13] clearable cumulative trip counter per stage
// [RULE_14] one shared test force flag, cleared by a five minute timeout
// [RULE_15] pick-up thresholds are set as a percentage of nominal voltage
// [RULE_16] each stage's pick-up of the active group is readable converted to primary volts
// [RULE_17] log eight latest faults with date, time, peak, delay and group
// [RULE_18] logged delay is percent of operate time, 100 meaning tripped
// [RULE_19] counters count rising edges of start and trip
// [RULE_20] trip drops together with start when the stage releases
`include "ovp_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module ovp_stages #(
    parameter int unsigned TICK_CYCLES = `OVP_TICK_CYCLES,
    parameter int unsigned FORCE_TICKS = `OVP_FORCE_TICKS
) (
    input  wire logic                  hclk,               // system clock
    input  wire logic                  hresetn,            // async reset, low
    input  wire logic                  hsel,               // slave select
    input  wire logic [31:0]           haddr,              // byte address
    input  wire logic [1:0]            htrans,             // transfer type
    input  wire logic                  hwrite,             // write request
    input  wire logic [2:0]            hsize,              // word only
    input  wire logic [31:0]           hwdata,             // write data
    input  wire logic                  hready,             // bus ready
    output logic                       hreadyout,          // slave ready
    output logic                       hresp,              // always okay
    output logic [31:0]                hrdata,             // read data
    input  wire ovp_pkg::ovp_volt_type volt_in,            // line magnitudes
    input  wire logic [2:0]            block_in,           // per-stage block
    input  wire logic [7:0]            digital_in,         // digital inputs
    input  wire logic [7:0]            virtual_in,         // virtual inputs
    input  wire logic [7:0]            indicator_signal_n, // indicator signals
    input  wire logic [7:0]            soft_output_n,      // virtual outputs
    input  wire logic [7:0]            function_key_n,     // function keys
    input  wire ovp_pkg::ovp_stamp_type stamp_in,          // date and time
    output ovp_pkg::ovp_flags_type     flags_o             // start and trip
);
    import ovp_pkg::*;

    // bus slave: writes zero wait, reads one wait so hrdata comes from a flop
    logic [11:0]   dph_addr_r;
    logic          dph_wr_r;
    logic          dph_rd_r;
    logic          rd_done_r;
    logic [31:0]   hrdata_r;
    logic [31:0]   rd_mux;

    wire addr_take = hsel & hready & htrans[1];
    wire wr_en     = dph_wr_r & hready;
    wire [11:0] wa = dph_addr_r;

    assign hreadyout = ~(dph_rd_r & ~rd_done_r);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_addr_r <= 12'h000;
            dph_wr_r   <= 1'b0;
            dph_rd_r   <= 1'b0;
            rd_done_r  <= 1'b0;
            hrdata_r   <= 32'h0000_0000;
        end
        else if (dph_rd_r & ~rd_done_r)
        begin
            hrdata_r  <= rd_mux;
            rd_done_r <= 1'b1;
        end
        else if (hready)
        begin
            dph_addr_r <= haddr[11:0];
            dph_wr_r   <= addr_take & hwrite;
            dph_rd_r   <= addr_take & ~hwrite;
            rd_done_r  <= 1'b0;
        end
    end

    wire wr_ctrl  = wr_en & (wa == `OVP_ADDR_CTRL);
    wire wr_force = wr_en & (wa == `OVP_ADDR_FORCE);
    wire wr_hyst  = wr_en & (wa == `OVP_ADDR_HYST);
    wire wr_hold  = wr_en & (wa == `OVP_ADDR_HOLD);
    wire wr_unom  = wr_en & (wa == `OVP_ADDR_UNOM);
    wire wr_clr   = wr_en & (wa == `OVP_ADDR_CNT_CLR);
    wire wr_lsel  = wr_en & (wa == `OVP_ADDR_LOG_SEL);
    wire set_hit  = (wa >= `OVP_ADDR_SET_BASE) & (wa < `OVP_ADDR_SET_END);
    wire [3:0] set_idx = wa[5:2];

    // settings, status of the configuration
    ovp_ctrl_type  ctrl_r;
    ovp_force_type force_r;
    logic [9:0]    hyst_r;
    logic [15:0]   release_hold_time;
    logic [19:0]   unom_r;
    logic [2:0]    log_sel_r;
    logic [31:0]   set_r [12];
    logic [15:0]   tick_cnt_r;
    logic          tick_r;
    logic [18:0]   force_cnt_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r            <= ovp_ctrl_type'(`OVP_CTRL_RESET);
            hyst_r            <= `OVP_HYST_RESET;
            release_hold_time <= `OVP_HOLD_RESET;
            unom_r            <= `OVP_UNOM_RESET;
            log_sel_r         <= 3'h0;
            for (int i = 0; i < 12; i++)
                set_r[i] <= `OVP_SET_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= ovp_ctrl_type'({22'h000000, hwdata[9:0]});
            // a dead band of a full pick-up or more would never release
            if (wr_hyst && hwdata[9:0] < `OVP_PERMILLE)
                hyst_r <= hwdata[9:0];
            if (wr_hold)
                release_hold_time <= hwdata[15:0];
            if (wr_unom)
                unom_r <= hwdata[19:0];
            if (wr_lsel)
                log_sel_r <= hwdata[2:0];
            if (wr_en & set_hit)
                set_r[set_idx] <= hwdata;
        end
    end

    // millisecond time base for every delay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end
        else
        begin
            tick_r     <= (tick_cnt_r == 16'(TICK_CYCLES - 1));
            tick_cnt_r <= (tick_cnt_r == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_r + 16'h0001;
        end
    end

    // [RULE_14] shared force flag with timeout
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            force_r     <= ovp_force_type'(32'h0000_0000);
            force_cnt_r <= 19'h00000;
        end
        else if (wr_force)
        begin
            // software set wins over a timeout in the same cycle
            force_r     <= ovp_force_type'({25'h0000000, hwdata[6:0]});
            force_cnt_r <= 19'h00000;
        end
        else if (force_r.flag && tick_r)
        begin
            force_cnt_r <= force_cnt_r + 19'h00001;
            if (force_cnt_r == 19'(FORCE_TICKS - 1))
                force_r.flag <= 1'b0;
        end
    end

    // [RULE_01] [RULE_02] supervised value is the largest fundamental magnitude
    wire [15:0] v_ab = volt_in.line_voltage_a_b;
    wire [15:0] v_bc = volt_in.line_voltage_b_c;
    wire [15:0] v_ca = volt_in.line_voltage_c_a;
    wire [15:0] v_max1 = (v_ab > v_bc) ? v_ab : v_bc;
    wire [15:0] umax   = (v_max1 > v_ca) ? v_max1 : v_ca;
    wire [25:0] umax_k = {10'h000, umax} * {16'h0000, `OVP_PERMILLE};
    wire [9:0]  rel_k  = `OVP_PERMILLE - hyst_r;

    // [RULE_09] [RULE_10] active group from manual setting or a selected line
    logic [7:0] src_vec;
    assign src_vec = (ctrl_r.group_select_source == OVP_SRC_DIGITAL)   ? digital_in :
                     (ctrl_r.group_select_source == OVP_SRC_VIRTUAL)   ? virtual_in :
                     (ctrl_r.group_select_source == OVP_SRC_INDICATOR) ? indicator_signal_n :
                     (ctrl_r.group_select_source == OVP_SRC_SOFT_OUT)  ? soft_output_n :
                     (ctrl_r.group_select_source == OVP_SRC_FKEY)      ? function_key_n :
                                                                         8'h00;
    wire [1:0] active_group_index = src_vec[ctrl_r.sel_line] ? ctrl_r.alt_group
                                                             : ctrl_r.manual_group;

    wire logic [2:0]       start_w;
    wire logic [2:0]       trip_w;
    wire logic [2:0][15:0] op_cnt_w;
    wire logic [2:0][15:0] optime_w;
    wire logic [2:0][15:0] s_count_w;
    wire logic [2:0][15:0] t_count_w;
    wire logic [2:0][31:0] prim_w;
    ovp_status_type        status_w [3];

    // [RULE_05] three identical stages, stage 0 owning the release delay
    for (genvar s = 0; s < 3; s++)
    begin : g_stage
        logic        picked_r;
        logic [15:0] op_cnt_r;
        logic [15:0] rel_cnt_r;
        logic        start_d_r;
        logic        trip_d_r;
        logic [15:0] start_event_count;
        logic [15:0] trip_event_count;

        // [RULE_15] pick-up in 0.1 % of nominal, operate time in ms
        wire [31:0] word   = set_r[s * 4 + int'(active_group_index)];
        wire [15:0] pick   = word[15:0];
        wire [15:0] optime = word[31:16];
        wire [15:0] hold   = (s == 0) ? release_hold_time : 16'h0000;
        wire [25:0] pick_k = {10'h000, pick} * {16'h0000, rel_k};
        wire        over   = umax > pick;
        wire        below  = umax_k < pick_k;
        wire        blk    = block_in[s];
        // [RULE_04] [RULE_20] trip only while picked up
        wire        trip_now = picked_r & (op_cnt_r >= optime);
        wire        clr_s  = wr_clr & hwdata[s];
        wire        clr_t  = wr_clr & hwdata[s + 3];

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                picked_r  <= 1'b0;
                op_cnt_r  <= 16'h0000;
                rel_cnt_r <= 16'h0000;
            end
            else if (blk)
            begin
                picked_r  <= 1'b0;
                op_cnt_r  <= 16'h0000;
                rel_cnt_r <= 16'h0000;
            end
            else
            begin
                // [RULE_03] [RULE_08] pick above setting, release below dead band
                if (!picked_r && over)
                    picked_r <= 1'b1;
                else if (picked_r && below)
                    picked_r <= 1'b0;
                if (picked_r)
                begin
                    rel_cnt_r <= 16'h0000;
                    // [RULE_07] counting continues from a retained value
                    if (tick_r && op_cnt_r != 16'hFFFF)
                        op_cnt_r <= op_cnt_r + 16'h0001;
                end
                // [RULE_06] timer held until the release delay has run out
                else if (rel_cnt_r >= hold)
                begin
                    op_cnt_r  <= 16'h0000;
                    rel_cnt_r <= 16'h0000;
                end
                else if (tick_r)
                    rel_cnt_r <= rel_cnt_r + 16'h0001;
            end
        end

        // [RULE_12] [RULE_13] [RULE_19] edge counters, an edge beats a clear
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                start_d_r         <= 1'b0;
                trip_d_r          <= 1'b0;
                start_event_count <= 16'h0000;
                trip_event_count  <= 16'h0000;
            end
            else
            begin
                start_d_r <= picked_r;
                trip_d_r  <= trip_now;
                if (picked_r & ~start_d_r)
                    start_event_count <= clr_s ? 16'h0001 : start_event_count + 16'h0001;
                else if (clr_s)
                    start_event_count <= 16'h0000;
                if (trip_now & ~trip_d_r)
                    trip_event_count <= clr_t ? 16'h0001 : trip_event_count + 16'h0001;
                else if (clr_t)
                    trip_event_count <= 16'h0000;
            end
        end

        // [RULE_16] pick-up in primary volts
        wire [35:0] prim_full = ({20'h00000, pick} * {16'h0000, unom_r}) / 36'(`OVP_PERMILLE);

        assign start_w[s]   = picked_r;
        assign trip_w[s]    = trip_now;
        assign op_cnt_w[s]  = op_cnt_r;
        assign optime_w[s]  = optime;
        assign s_count_w[s] = start_event_count;
        assign t_count_w[s] = trip_event_count;
        assign prim_w[s]    = prim_full[31:0];
        // [RULE_11] blocked outranks trip outranks start
        assign status_w[s]  = blk ? OVP_BLOCKED : trip_now ? OVP_TRIP :
                              picked_r ? OVP_START : OVP_IDLE;
    end

    // outputs, replaced by the forced pattern while the test flag stands
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flags_o <= ovp_flags_type'(6'h00);
        else if (force_r.flag)
            flags_o <= '{start: force_r.start, trip: force_r.trip};
        else
            flags_o <= '{start: start_w, trip: trip_w};
    end

    // fault recording: one entry when a stage's start falls
    logic [2:0]  start_prev_r;
    logic [2:0]  trip_prev_r;
    logic [15:0] peak_r;
    logic [2:0]  wptr_r;
    logic [3:0]  log_count_r;
    ovp_log_type log_r [8];

    wire [2:0] fall    = start_prev_r & ~start_w;
    wire [1:0] fsel    = fall[0] ? 2'd0 : fall[1] ? 2'd1 : 2'd2;
    wire [15:0] f_cnt  = op_cnt_w[fsel];
    wire [15:0] f_time = optime_w[fsel];
    // [RULE_18] tripped or full time reads as 100, otherwise cnt*100/time
    wire [22:0] f_num  = {7'h00, f_cnt} * 23'd100;
    wire [22:0] f_div  = (f_time == 16'h0000) ? 23'd100 : f_num / {7'h00, f_time};
    wire [7:0]  f_el   = (trip_prev_r[fsel] || f_div >= 23'd100) ? `OVP_PCT_FULL : f_div[7:0];
    wire        any_st = |start_w;
    wire [2:0]  rd_slot = wptr_r - 3'h1 - log_sel_r;

    // [RULE_17] eight-entry ring of the latest faults
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_prev_r <= 3'h0;
            trip_prev_r  <= 3'h0;
            peak_r       <= 16'h0000;
            wptr_r       <= 3'h0;
            log_count_r  <= 4'h0;
            for (int i = 0; i < 8; i++)
                log_r[i] <= ovp_log_type'(96'h0);
        end
        else
        begin
            start_prev_r <= start_w;
            trip_prev_r  <= trip_w;
            if (any_st && (start_prev_r == 3'h0 || umax > peak_r))
                peak_r <= umax;
            if (|fall)
            begin
                log_r[wptr_r] <= '{stamp: stamp_in,
                                   info: '{rsv: 4'h0, stage: fsel,
                                           active_group_index: active_group_index,
                                           elapsed_delay_percent: f_el,
                                           fault_peak_voltage: peak_r}};
                wptr_r <= wptr_r + 3'h1;
                if (log_count_r != 4'h8)
                    log_count_r <= log_count_r + 4'h1;
            end
        end
    end

    wire [31:0] status_word = {umax, trip_w, start_w, active_group_index,
                               2'h0, status_w[2], status_w[1], status_w[0]};
    wire        cnt_hit  = (wa[11:4] == `OVP_ADDR_COUNT_BASE >> 4) && (wa[3:2] != 2'h3);
    wire        prim_hit = (wa[11:4] == `OVP_ADDR_PRIM_BASE >> 4) && (wa[3:2] != 2'h3);

    // read selection, unmapped words read zero
    assign rd_mux = (wa == `OVP_ADDR_CTRL)     ? 32'(ctrl_r) :
                    (wa == `OVP_ADDR_FORCE)    ? 32'(force_r) :
                    (wa == `OVP_ADDR_HYST)     ? {22'h000000, hyst_r} :
                    (wa == `OVP_ADDR_HOLD)     ? {16'h0000, release_hold_time} :
                    (wa == `OVP_ADDR_UNOM)     ? {12'h000, unom_r} :
                    (wa == `OVP_ADDR_STATUS)   ? status_word :
                    (wa == `OVP_ADDR_LOG_SEL)  ? {20'h00000, log_count_r, 5'h00, log_sel_r} :
                    (wa == `OVP_ADDR_LOG_DATE) ? log_r[rd_slot].stamp.date :
                    (wa == `OVP_ADDR_LOG_TIME) ? log_r[rd_slot].stamp.tod_ms :
                    (wa == `OVP_ADDR_LOG_INFO) ? 32'(log_r[rd_slot].info) :
                    cnt_hit  ? {t_count_w[wa[3:2]], s_count_w[wa[3:2]]} :
                    prim_hit ? prim_w[wa[3:2]] :
                    set_hit  ? set_r[set_idx] :
                               32'h0000_0000;

    wire unused_ok = &{1'b0, hsize, haddr[31:12]};

endmodule // ovp_stages

`default_nettype wire

/* tb/ovp_front_model.sv */
// front end model: three fundamental line magnitudes
// assumes the bench supplies the wanted peak and a random word
`timescale 1ns/1ns
`default_nettype none
module ovp_front_model
(
    input  wire logic [15:0]      peak,  // wanted maximum
    input  wire logic [31:0]      rnd,   // random word
    output ovp_pkg::ovp_volt_type volt_o // line magnitudes
);
    import ovp_pkg::*;
    wire logic [15:0] low_a = peak - ((peak >> 3) & rnd[15:0]);
    wire logic [15:0] low_b = peak - ((peak >> 3) & rnd[31:16]);
    assign volt_o = (rnd[9:8] == 2'h0) ? {peak, low_a, low_b}
                  : (rnd[9:8] == 2'h1) ? {low_a, peak, low_b} : {low_a, low_b, peak};
endmodule // ovp_front_model
`default_nettype wire

/* tb/ovp_checker.sv */
// port assertions for the overvoltage stages
// assumes forced flags keep trip within start
`timescale 1ns/1ns
`default_nettype none
module ovp_chk
(
    input wire logic                   hclk,      // clock
    input wire logic                   hresetn,   // reset, low
    input wire logic                   hsel,      // select
    input wire logic [1:0]             htrans,    // transfer
    input wire logic                   hwrite,    // write
    input wire logic                   hready,    // ready in
    input wire logic                   hreadyout, // ready out
    input wire logic                   hresp,     // response
    input wire logic [2:0]             block_in,  // blocks
    input wire ovp_pkg::ovp_flags_type flags_o    // flags
);
    import ovp_pkg::*;
    wire logic rd_req = hsel && hready && htrans[1] && !hwrite;
    wire logic wr_req = hsel && hready && htrans[1] && hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_trip_in_start; (flags_o.trip & ~flags_o.start) == 3'h0; endproperty
    a_trip_in_start: assert property (p_trip_in_start)
        else $error("trip without start");
    property p_fall_joint; $fell(flags_o.trip[1]) |-> $fell(flags_o.start[1]); endproperty
    a_fall_joint: assert property (p_fall_joint)
        else $error("trip fell alone");
    property p_block; (block_in == 3'h7)[*4] |=> flags_o == 6'h00; endproperty
    a_block: assert property (p_block)
        else $error("flags while blocked");
    property p_reset_idle; $rose(hresetn) |-> flags_o == 6'h00 && hreadyout; endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle after reset");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay)
        else $error("response not okay");
    property p_rd_wait; rd_req |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait wrong");
    property p_wr_fast; wr_req |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast)
        else $error("write stalled");
    property p_one_wait; !hreadyout |=> hreadyout; endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("wait too long");
endmodule // ovp_chk

bind ovp_stages ovp_chk chk_u
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .block_in(block_in),
    .flags_o(flags_o)
);
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the overvoltage stages
// assumes front model and checker bind compiled alongside
`include "ovp_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ovp_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rd_ph = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] block_in = 3'h0;
    logic [15:0] peak = 16'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rnd = 32'h4A58;
    logic [39:0] src_l = 40'h0;
    logic [63:0] ent;
    logic [63:0] exp_q [$];
    int error_cnt = 0;
    int num_checks = 0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    ovp_volt_type volt;
    ovp_flags_type flags_o;
    always #10 hclk = ~hclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always @(posedge hclk) rnd <= lfsr(rnd);
    ovp_front_model fe_u (.peak(peak), .rnd(rnd), .volt_o(volt));
    ovp_stages #(.TICK_CYCLES(4), .FORCE_TICKS(5)) dut_u
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .volt_in(volt),
        .block_in(block_in), .digital_in(src_l[7:0]), .virtual_in(src_l[15:8]),
        .indicator_signal_n(src_l[23:16]), .soft_output_n(src_l[31:24]),
        .function_key_n(src_l[39:32]), .stamp_in({rnd, rnd}), .flags_o(flags_o)
    );
    task automatic complete_run;
        $display("checks %0d fails %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdy;
        int n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            n++;
            @(negedge hclk);
        end
        if (n == 50)
        begin
            check("ready", 32'h0, 32'h1);
            complete_run();
        end
        @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, m);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        if (!w)
            exp_q.push_back({m, d});
        rd_ph <= !w;
        rdy();
        rd_ph <= 1'b0;
    endtask
    task automatic fl(input int n, input logic [5:0] e);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
        check("flags", {26'h0, flags_o}, {26'h0, e});
        @(posedge hclk);
    endtask
    always @(negedge hclk)
        if (rd_ph && hreadyout)
        begin
            ent = exp_q.pop_front();
            check("rdata", hrdata & ent[63:32], ent[31:0]);
        end
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, `OVP_ADDR_HYST, 32'h1E, '1);
        bus(0, `OVP_ADDR_SET_BASE, `OVP_SET_RESET, '1);
        bus(0, `OVP_ADDR_PRIM_BASE, 32'd11000, '1);
        bus(0, 32'h200, 32'h0, '1);
        $display("registers done");
        bus(1, 32'h90, 32'h0002_047E, 0);
        bus(1, 32'hA0, 32'h0003_04B0, 0);
        peak <= 16'h04B1;
        repeat (40) @(posedge hclk);
        bus(0, `OVP_ADDR_STATUS, 32'h04B1_DC3E, '1);
        peak <= 16'd1150;
        fl(4, 6'b011_010);
        peak <= 16'd1067;
        fl(4, 6'b001_000);
        peak <= 16'd1066;
        fl(4, 6'b000_000);
        bus(0, 32'h30, 32'h0000_0001, '1);
        bus(0, 32'h34, 32'h0001_0001, '1);
        bus(1, `OVP_ADDR_CNT_CLR, 32'h3F, 0);
        bus(0, 32'h38, 32'h0, '1);
        $display("stages done");
        bus(1, `OVP_ADDR_HOLD, 32'd10, 0);
        bus(1, 32'h80, 32'h0006_044C, 0);
        repeat (60) @(posedge hclk);
        peak <= 16'd1120;
        repeat (20) @(posedge hclk);
        peak <= 16'd1000;
        repeat (12) @(posedge hclk);
        peak <= 16'd1120;
        fl(16, 6'b001_001);
        peak <= 16'd1000;
        repeat (60) @(posedge hclk);
        peak <= 16'd1120;
        fl(16, 6'b001_000);
        $display("release delay done");
        peak <= 16'd1050;
        bus(1, 32'h84, 32'h0064_03E8, 0);
        for (int s = 1; s < 6; s++)
        begin
            bus(1, `OVP_ADDR_CTRL, (s << 4) | 32'h4, 0);
            src_l <= 40'h1 << (8 * (s - 1));
            repeat (4) @(posedge hclk);
            bus(0, `OVP_ADDR_STATUS, 32'h500, 32'h700);
        end
        bus(1, `OVP_ADDR_CTRL, 32'h4, 0);
        src_l <= '1;
        repeat (4) @(posedge hclk);
        bus(0, `OVP_ADDR_STATUS, 32'h0, 32'h700);
        bus(1, `OVP_ADDR_FORCE, 32'h1B, 0);
        fl(2, 6'b101_001);
        fl(30, 6'b000_000);
        block_in <= 3'h7;
        repeat (6) @(posedge hclk);
        bus(0, `OVP_ADDR_STATUS, 32'h15, 32'h3F);
        fl(0, 6'b000_000);
        $display("groups and block done");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
